// ==== shared/flag_pkg.sv ====
package flag_pkg;
  // Time figures in their own units, with cycle counts derived from REF_CLK (200 MHz)
  localparam int CLK_MHZ = 200;
  localparam int TX_ACTIVE_MAX_US = 1500;
  localparam int TX_ACTIVE_MAX_CYC = TX_ACTIVE_MAX_US * CLK_MHZ;
  localparam int CORE_UV_DET_US = 10;
  localparam int CORE_UV_DET_CYC = CORE_UV_DET_US * CLK_MHZ;
  localparam int CORE_UV_REC_US = 10;
  localparam int CORE_UV_REC_CYC = CORE_UV_REC_US * CLK_MHZ;
  localparam int IO_UV_DET_US = 10;
  localparam int IO_UV_DET_CYC = IO_UV_DET_US * CLK_MHZ;
  localparam int IO_UV_REC_US = 10;
  localparam int IO_UV_REC_CYC = IO_UV_REC_US * CLK_MHZ;
  localparam int ERR_STABLE_US = 50;
  localparam int ERR_STABLE_CYC = ERR_STABLE_US * CLK_MHZ;
  localparam int MODE_CHANGE_US = 100;
  localparam int MODE_CHANGE_CYC = MODE_CHANGE_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam logic [4:0] FRAME_EDGES = 5'h10;

  // Six error contributors, in status-bit order
  typedef struct packed {
    logic frame_err;
    logic io_uv;
    logic core_uv;
    logic tx_timeout;
    logic thermal;
    logic bus_err;
  } err_flags_t;

  localparam err_flags_t ERR_NONE = err_flags_t'(6'h0);
  localparam err_flags_t UV_AT_POWERUP = err_flags_t'(6'h18);

  typedef enum logic [0:0] {
    IND_LATCHED = 1'b0,
    IND_TRACK = 1'b1
  } ind_mode_t;
endpackage

// ==== hw/flag_logic.sv ====
`timescale 1ns/1ps
module flag_logic #(
  parameter int TX_MAX = flag_pkg::TX_ACTIVE_MAX_CYC,
  parameter int CUV_DET = flag_pkg::CORE_UV_DET_CYC,
  parameter int CUV_REC = flag_pkg::CORE_UV_REC_CYC,
  parameter int IUV_DET = flag_pkg::IO_UV_DET_CYC,
  parameter int IUV_REC = flag_pkg::IO_UV_REC_CYC,
  parameter int ERR_STABLE = flag_pkg::ERR_STABLE_CYC,
  parameter int MODE_CHG = flag_pkg::MODE_CHANGE_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic STANDBY_CONTROL_N,
  input wire logic TRANSMIT_ENABLE_N,
  input wire logic GUARDIAN_ENABLE,
  input wire logic TXD,
  input wire logic BUS_DATA,
  input wire logic WAKE_DETECT,
  input wire logic OVER_TEMP,
  input wire logic CORE_SUPPLY_LOW,
  input wire logic IO_SUPPLY_LOW,
  input wire logic CHIP_SELECT_N,
  input wire logic SERIAL_CLK,
  output logic ERROR_INDICATOR_N,
  output logic RXD_FORCE_LOW,
  output logic NORMAL_MODE,
  output logic TX_READY,
  output logic POWER_ON,
  output logic WAKE_FLAG,
  output logic TRACK_MODE,
  output logic CS_PULL_DOWN,
  output logic [5:0] STATUS_BITS,
  output logic POWER_ON_STATUS
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef logic [flag_pkg::CNT_W-1:0] cnt_t;
  flag_pkg::err_flags_t flags_reg, flags_next;
  flag_pkg::err_flags_t stat_reg, stat_next;
  flag_pkg::ind_mode_t mode_reg, mode_next;
  logic normal_reg, normal_next, wake_reg, wake_next, pon_reg, pon_next, pons_reg, pons_next;
  logic ready_reg, ready_next, err_reg, err_next, pin_reg, pin_next, rxl_reg, rxl_next;
  logic txd_d_reg, txd_d_next, cs_d_reg, cs_d_next, bad_reg, bad_next, cmp_reg, cmp_next;
  logic [4:0] edges_reg, edges_next;
  logic sck_d_reg, sck_d_next;
  cnt_t tx_cnt_reg, tx_cnt_next, cuv_cnt_reg, cuv_cnt_next, iuv_cnt_reg, iuv_cnt_next;
  cnt_t stab_cnt_reg, stab_cnt_next, mc_cnt_reg, mc_cnt_next;

  function automatic cnt_t bump(input cnt_t c);
    bump = (c == {flag_pkg::CNT_W{1'b1}}) ? c : c + cnt_t'(1);
  endfunction

  // Filter counter: counts while the raw level disagrees with the flag
  function automatic cnt_t filt(input cnt_t c, input logic raw, input logic flag);
    filt = (raw != flag) ? bump(c) : '0;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic want_normal, enter_n, tx_on, cs_fall, cs_rise, sck_fall, ok_frame;
    want_normal = 1'b0;
    enter_n = 1'b0;
    tx_on = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    sck_fall = 1'b0;
    ok_frame = 1'b0;
    flags_next = flags_reg;
    stat_next = stat_reg;
    mode_next = mode_reg;
    wake_next = wake_reg;
    pon_next = pon_reg;
    pons_next = pons_reg;
    edges_next = edges_reg;
    bad_next = bad_reg;
    cmp_next = 1'b0;
    // Undervoltage filters; a flag forces Standby
    cuv_cnt_next = filt(cuv_cnt_reg, CORE_SUPPLY_LOW, flags_reg.core_uv);
    if (!flags_reg.core_uv && int'(cuv_cnt_next) >= CUV_DET) begin
      flags_next.core_uv = 1'b1;
      cuv_cnt_next = '0;
    end else if (flags_reg.core_uv && int'(cuv_cnt_next) >= CUV_REC) begin
      flags_next.core_uv = 1'b0;
      cuv_cnt_next = '0;
      pon_next = 1'b1;
      pons_next = 1'b1;
    end
    iuv_cnt_next = filt(iuv_cnt_reg, IO_SUPPLY_LOW, flags_reg.io_uv);
    if (!flags_reg.io_uv && int'(iuv_cnt_next) >= IUV_DET) begin
      flags_next.io_uv = 1'b1;
      iuv_cnt_next = '0;
    end else if (flags_reg.io_uv && int'(iuv_cnt_next) >= IUV_REC) begin
      flags_next.io_uv = 1'b0;
      iuv_cnt_next = '0;
    end
    want_normal = STANDBY_CONTROL_N && !flags_reg.core_uv && !flags_reg.io_uv;
    normal_next = want_normal;
    enter_n = want_normal && !normal_reg;
    // Remote wakeup; only an already set I/O flag is cleared, so a filter set wins
    if (!normal_reg && !flags_reg.core_uv && WAKE_DETECT && !wake_reg) begin
      wake_next = 1'b1;
      if (flags_reg.io_uv) begin
        flags_next.io_uv = 1'b0;
        iuv_cnt_next = '0;
      end
    end else if (enter_n) begin
      wake_next = 1'b0;
    end
    if (enter_n) begin
      pon_next = 1'b0;
    end
    // Transmit timeout
    tx_cnt_next = (normal_reg && !TRANSMIT_ENABLE_N) ? bump(tx_cnt_reg) : '0;
    if (!normal_reg || TRANSMIT_ENABLE_N) begin
      flags_next.tx_timeout = 1'b0;
    end else if (int'(tx_cnt_next) > TX_MAX) begin
      flags_next.tx_timeout = 1'b1;
    end
    // Thermal shutdown
    if (!normal_reg) begin
      flags_next.thermal = 1'b0;
    end else if (OVER_TEMP) begin
      flags_next.thermal = 1'b1;
    end else if (TRANSMIT_ENABLE_N) begin
      flags_next.thermal = 1'b0;
    end
    ready_next = normal_next && !flags_next.tx_timeout && GUARDIAN_ENABLE
      && !flags_next.thermal;
    // Bus error: compare one cycle after each transmit data edge
    tx_on = ready_reg && !TRANSMIT_ENABLE_N;
    txd_d_next = TXD;
    cmp_next = tx_on && (TXD != txd_d_reg);
    if (!normal_reg || TRANSMIT_ENABLE_N) begin
      flags_next.bus_err = 1'b0;
    end else if (cmp_reg && tx_on) begin
      flags_next.bus_err = (BUS_DATA != TXD);
    end
    // Serial frame check
    cs_d_next = CHIP_SELECT_N;
    sck_d_next = SERIAL_CLK;
    cs_fall = cs_d_reg && !CHIP_SELECT_N;
    cs_rise = !cs_d_reg && CHIP_SELECT_N;
    sck_fall = !CHIP_SELECT_N && sck_d_reg && !SERIAL_CLK;
    if (cs_fall) begin
      flags_next.frame_err = 1'b0;
      edges_next = '0;
      bad_next = SERIAL_CLK;
    end else if (sck_fall && edges_reg != 5'h1F) begin
      edges_next = edges_reg + 5'h01;
    end
    if (cs_rise) begin
      if (bad_reg || SERIAL_CLK || edges_reg != flag_pkg::FRAME_EDGES) begin
        flags_next.frame_err = 1'b1;
      end else begin
        ok_frame = (mode_reg == flag_pkg::IND_LATCHED);
      end
    end
    // Indication mode
    mc_cnt_next = (!CHIP_SELECT_N && SERIAL_CLK && !flags_reg.io_uv) ? bump(mc_cnt_reg) : '0;
    if (mode_reg == flag_pkg::IND_LATCHED && int'(mc_cnt_next) > MODE_CHG) begin
      mode_next = flag_pkg::IND_TRACK;
      flags_next.frame_err = 1'b0;
    end
    // Sticky status; a correct frame in latched mode clears bits whose flags are clear
    if (ok_frame) begin
      stat_next = stat_reg & flags_reg;
      if (!pon_reg && !(flags_reg.core_uv && !flags_next.core_uv)) begin
        pons_next = 1'b0;
      end
    end
    stat_next = stat_next | flags_next;
    // Common error
    if (|flags_next) begin
      err_next = 1'b1;
    end else if (mode_next == flag_pkg::IND_TRACK) begin
      err_next = 1'b0;
    end else begin
      err_next = err_reg && (stat_next != flag_pkg::ERR_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Pin indication with track-mode hold time
  // ----------------------------------------------------------------
  always_comb begin
    logic want;
    want = STANDBY_CONTROL_N ? !err_reg : !wake_reg;
    pin_next = pin_reg;
    stab_cnt_next = bump(stab_cnt_reg);
    if (want != pin_reg) begin
      if (mode_reg == flag_pkg::IND_LATCHED || int'(stab_cnt_reg) >= ERR_STABLE) begin
        pin_next = want;
        stab_cnt_next = '0;
      end
    end
    rxl_next = wake_reg && !STANDBY_CONTROL_N;
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      flags_reg <= flag_pkg::UV_AT_POWERUP;
      stat_reg <= flag_pkg::UV_AT_POWERUP;
      mode_reg <= flag_pkg::IND_LATCHED;
      normal_reg <= 1'b0;
      wake_reg <= 1'b0;
      pon_reg <= 1'b0;
      pons_reg <= 1'b0;
      ready_reg <= 1'b0;
      err_reg <= 1'b1;
      pin_reg <= 1'b1;
      rxl_reg <= 1'b0;
      txd_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
      bad_reg <= 1'b0;
      cmp_reg <= 1'b0;
      edges_reg <= '0;
      tx_cnt_reg <= '0;
      cuv_cnt_reg <= '0;
      iuv_cnt_reg <= '0;
      stab_cnt_reg <= '0;
      mc_cnt_reg <= '0;
    end else if (CLK_EN) begin
      flags_reg <= flags_next;
      stat_reg <= stat_next;
      mode_reg <= mode_next;
      normal_reg <= normal_next;
      wake_reg <= wake_next;
      pon_reg <= pon_next;
      pons_reg <= pons_next;
      ready_reg <= ready_next;
      err_reg <= err_next;
      pin_reg <= pin_next;
      rxl_reg <= rxl_next;
      txd_d_reg <= txd_d_next;
      cs_d_reg <= cs_d_next;
      sck_d_reg <= sck_d_next;
      bad_reg <= bad_next;
      cmp_reg <= cmp_next;
      edges_reg <= edges_next;
      tx_cnt_reg <= tx_cnt_next;
      cuv_cnt_reg <= cuv_cnt_next;
      iuv_cnt_reg <= iuv_cnt_next;
      stab_cnt_reg <= stab_cnt_next;
      mc_cnt_reg <= mc_cnt_next;
    end
  end

  assign ERROR_INDICATOR_N = pin_reg;
  assign RXD_FORCE_LOW = rxl_reg;
  assign NORMAL_MODE = normal_reg;
  assign TX_READY = ready_reg;
  assign POWER_ON = pon_reg;
  assign WAKE_FLAG = wake_reg;
  assign TRACK_MODE = mode_reg;
  assign CS_PULL_DOWN = mode_reg;
  assign STATUS_BITS = stat_reg;
  assign POWER_ON_STATUS = pons_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ready_terms_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    TX_READY |-> (NORMAL_MODE && !flags_reg.tx_timeout && !flags_reg.thermal))
    else $error("ready without its terms");
  common_err_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (|flags_reg) |-> err_reg)
    else $error("error flag not set");
  stat_sticky_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (CLK_EN && flags_reg.bus_err) |=> STATUS_BITS[0])
    else $error("status bit not latched");
  pin_drive_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (CLK_EN && STANDBY_CONTROL_N && err_reg && !TRACK_MODE) |=> !ERROR_INDICATOR_N)
    else $error("error pin not low");
  wake_rxd_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (CLK_EN && wake_reg && !STANDBY_CONTROL_N) |=> RXD_FORCE_LOW)
    else $error("receive not forced low");
  timeout_clr_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (CLK_EN && TRANSMIT_ENABLE_N) |=> !flags_reg.tx_timeout)
    else $error("timeout not cleared");
  uv_standby_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (CLK_EN && flags_reg.core_uv) |=> !NORMAL_MODE)
    else $error("normal during undervoltage");
  track_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    TRACK_MODE |=> TRACK_MODE && CS_PULL_DOWN)
    else $error("track mode lost");
endmodule

// ==== tb/status_host.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Host side of the serial status port
// ---------------------------------------------
module status_host (
  input wire logic clk,
  output logic cs_n,
  output logic sck
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end

  // Sixteen falls make a clean read-out; other counts are deliberate faults
  task automatic frame(input int falls, input int half);
    @(negedge clk);
    cs_n = 1'b0;
    repeat (half) @(negedge clk);
    repeat (falls) begin
      sck = 1'b1;
      repeat (half) @(negedge clk);
      sck = 1'b0;
      repeat (half) @(negedge clk);
    end
    cs_n = 1'b1;
    repeat (half) @(negedge clk);
  endtask

  // Left low with the clock high afterwards, as a permanent strap would be
  task automatic track_req(input int cycles);
    @(negedge clk);
    sck = 1'b1;
    cs_n = 1'b0;
    repeat (cycles) @(negedge clk);
  endtask
endmodule

// ==== tb/bus_driver_flag_error_logic_tb.sv ====
`timescale 1ns/1ps
// ---------------------------------------------
// Flag logic bench
// ---------------------------------------------
module bus_driver_flag_error_logic_tb;
  localparam int MODE_CHG = 10;
  localparam int TX_MAX = 20;
  localparam int UV_FILT = 4;
  localparam int ERR_STABLE = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic clk_en = 1'b1;
  logic stby_n = 1'b0;
  logic te_n = 1'b1;
  logic ge = 1'b1;
  logic txd = 1'b0;
  logic bus = 1'b0;
  logic wake = 1'b0;
  logic ot = 1'b0;
  logic cuv = 1'b0;
  logic iuv = 1'b0;
  logic cs_n;
  logic sck;
  logic err_n, rxd_low, nrm, txr, pon, wkf, trk, pd, pon_st;
  logic [5:0] st;
  logic [31:0] rnd = 32'h0000_83af;
  int fail_count = 0;
  int cmp_count = 0;
  logic [14:0] mq[$];
  logic [14:0] vq[$];
  event obs_ev;
  wire [14:0] obs = {pon_st, err_n, rxd_low, nrm, txr, pon, wkf, trk, pd, st};

  initial begin
    forever #2.5 clk = ~clk;
  end

  flag_logic #(.TX_MAX(TX_MAX), .CUV_DET(UV_FILT), .CUV_REC(UV_FILT), .IUV_DET(UV_FILT),
    .IUV_REC(UV_FILT), .ERR_STABLE(ERR_STABLE), .MODE_CHG(MODE_CHG)) DUT (
    .REF_CLK(clk), .NRST(nrst), .CLK_EN(clk_en), .STANDBY_CONTROL_N(stby_n),
    .TRANSMIT_ENABLE_N(te_n), .GUARDIAN_ENABLE(ge), .TXD(txd), .BUS_DATA(bus),
    .WAKE_DETECT(wake), .OVER_TEMP(ot), .CORE_SUPPLY_LOW(cuv), .IO_SUPPLY_LOW(iuv),
    .CHIP_SELECT_N(cs_n), .SERIAL_CLK(sck), .ERROR_INDICATOR_N(err_n),
    .RXD_FORCE_LOW(rxd_low), .NORMAL_MODE(nrm), .TX_READY(txr), .POWER_ON(pon),
    .WAKE_FLAG(wkf), .TRACK_MODE(trk), .CS_PULL_DOWN(pd), .STATUS_BITS(st),
    .POWER_ON_STATUS(pon_st));

  status_host HOST (.clk(clk), .cs_n(cs_n), .sck(sck));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Noted here, compared by the watcher once the outputs have settled
  task automatic expect_obs(input logic [14:0] m, input logic [14:0] v);
    mq.push_back(m);
    vq.push_back(v);
    -> obs_ev;
  endtask

  initial begin
    forever begin
      @(obs_ev);
      while (mq.size() > 0) begin
        check(obs & mq[0], vq[0]);
        void'(mq.pop_front());
        void'(vq.pop_front());
      end
    end
  end

  task automatic finish_test;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bounds the whole run, so a stuck sequence still reaches the verdict
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end

  initial begin
    cyc(4);
    nrst = 1'b1;
    cyc(1);
    expect_obs(15'h40FF, 15'h0018);
    cyc(10);
    expect_obs(15'h623F, 15'h6218);
    stby_n = 1'b1;
    cyc(6);
    expect_obs(15'h2E00, 15'h0C00);
    HOST.frame(16, 1);
    cyc(6);
    expect_obs(15'h603F, 15'h2000);
    te_n = 1'b0;
    repeat (6) begin
      rnd = lfsr(rnd);
      txd = rnd[0];
      bus = rnd[0];
      cyc(2);
    end
    expect_obs(15'h003F, 15'h0000);
    txd = ~txd;
    cyc(3);
    expect_obs(15'h0401, 15'h0401);
    te_n = 1'b1;
    bus = txd;
    cyc(3);
    HOST.frame(16, 2);
    cyc(6);
    expect_obs(15'h203F, 15'h2000);
    te_n = 1'b0;
    cyc(30);
    expect_obs(15'h2404, 15'h0004);
    te_n = 1'b1;
    cyc(4);
    expect_obs(15'h0400, 15'h0400);
    ot = 1'b1;
    cyc(4);
    expect_obs(15'h0402, 15'h0002);
    ot = 1'b0;
    cyc(4);
    expect_obs(15'h0400, 15'h0400);
    HOST.frame(15, 1);
    cyc(6);
    expect_obs(15'h203F, 15'h0026);
    HOST.frame(16, 1);
    cyc(6);
    expect_obs(15'h203F, 15'h2000);
    ge = 1'b0;
    cyc(3);
    expect_obs(15'h0400, 15'h0000);
    ge = 1'b1;
    cuv = 1'b1;
    cyc(8);
    expect_obs(15'h0808, 15'h0008);
    cuv = 1'b0;
    cyc(10);
    stby_n = 1'b0;
    cyc(4);
    expect_obs(15'h4C00, 15'h4000);
    wake = 1'b1;
    cyc(4);
    wake = 1'b0;
    cyc(4);
    expect_obs(15'h3100, 15'h1100);
    HOST.track_req(MODE_CHG + 6);
    expect_obs(15'h00C0, 15'h00C0);
    // Track mode: a one-cycle thermal event must stay visible for the hold time
    stby_n = 1'b1;
    cyc(12);
    clk_en = 1'b0;
    ot = 1'b1;
    cyc(3);
    expect_obs(15'h2002, 15'h2000);
    clk_en = 1'b1;
    cyc(1);
    ot = 1'b0;
    cyc(5);
    expect_obs(15'h2002, 15'h0002);
    cyc(8);
    expect_obs(15'h2000, 15'h2000);
    cyc(2);
    finish_test();
  end
endmodule
